// *** tlm_params.svh ***
// Constants of the temperature limit alarm block: register addresses, field layouts, timing.
// Assumes core_clk at 40 MHz; the register port runs on the SMBus engine clock.
// Function
// - Limit-mask register bit 6 set keeps the local channel off the limit interrupt.
// - Limit-mask bits 3..0 mask remote channels 4..1 from the limit interrupt.
// - Trip-mask bit 3 masks remote 4, bit 0 masks remote 1 from the trip output.
// - Cleared limit interrupt stays off; reasserts at next conversion end if fault remains.
// - Trip status flags clear only on reading status 2, even with fault present.
// - Reading status 2 leaves the trip output unchanged.
// - Trip output holds until temperature drops below trip threshold minus 4 degrees.
// - Config 1 bit 3 enables resistance cancellation; channel 1 conversion takes 125 ms more.
// - Status 1 bit 6 sets when local result exceeds the local limit.
// - Status 1 bits 3..0 set when remote channels 4..1 exceed their limits.
// - A faulted remote diode channel is skipped in the measurement sequence.
// - Reading status 1 or finishing alert response deasserts the limit interrupt.
// - Trip asserts when temperature is strictly above the trip threshold.
// - Limit flags clear on read and set again after next over-limit conversion.
// - Limit interrupt needs an unmasked limit flag and a latch set at conversion end, cleared by status 1 read or alert response.
`ifndef TLM_PARAMS_SVH
`define TLM_PARAMS_SVH
`define TLM_ADDR_CFG1      8'h41
`define TLM_ADDR_CFG2      8'h42
`define TLM_ADDR_CFG3      8'h43
`define TLM_ADDR_STAT1     8'h44
`define TLM_ADDR_STAT2     8'h45
`define TLM_CFG1_WMASK     8'hb8
`define TLM_CFG2_WMASK     8'h4f
`define TLM_CFG3_WMASK     8'h09
`define TLM_CFG1_POR_BIT   6
`define TLM_CFG1_STOP_BIT  7
`define TLM_CFG1_RC_BIT    3
`define TLM_CFG_RESET      8'h00
`define TLM_TRIP_HYST_DEGC 9'sd4
`define TLM_CONV_CYC       64
`define TLM_RC_EXTRA_MS    125
`define TLM_CORE_CLK_KHZ   40000
`define TLM_RC_EXTRA_CYC   (`TLM_RC_EXTRA_MS * `TLM_CORE_CLK_KHZ)
`endif

// *** tlm_pkg.sv ***
// Types shared by the temperature limit alarm block.
// Channel 0 is local, channels 1 to 4 are remote diodes.
package tlm_pkg;
    typedef logic        [2:0] tlm_chan_t;
    typedef logic signed [7:0] tlm_temp_t;
    typedef enum logic [1:0]
    {
        TLM_SEQ_PICK = 2'b00,
        TLM_SEQ_CONV = 2'b01,
        TLM_SEQ_DONE = 2'b10
    } tlm_seq_state_t;
endpackage

// *** tlm_seq_if.sv ***
// Carrier between the alarm logic and the conversion sequencer.
// Everything here lives in the core_clk domain.
`timescale 1ns/100ps
`default_nettype none
interface tlm_seq_if;
    import tlm_pkg::*;
    logic      conv_start;
    logic      conv_end;
    tlm_chan_t conv_chan;
    logic      halt;
    logic      res_cancel;
    logic [3:0] fault;
    modport seq (output conv_start, output conv_end, output conv_chan,
                 input halt, input res_cancel, input fault);
    modport ctl (input conv_start, input conv_end, input conv_chan,
                 output halt, output res_cancel, output fault);
endinterface
`default_nettype wire

// *** tlm_conv_seq.sv ***
// Conversion sequencer: walks local and remote channels, times each conversion.
// Assumes synchronised fault, halt and cancel levels on core_clk.
`timescale 1ns/100ps
`default_nettype none
`include "tlm_params.svh"
module tlm_conv_seq #(
    parameter int unsigned CONV_CYC     = `TLM_CONV_CYC,
    parameter int unsigned RC_EXTRA_CYC = `TLM_RC_EXTRA_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    tlm_seq_if.seq   sif
);
    import tlm_pkg::*;

    tlm_seq_state_t state_q;
    tlm_chan_t      chan_q;
    logic [31:0]    cnt_q;
    logic           start_q;
    logic           end_q;

    wire [4:0]  fault_vec = {sif.fault, 1'b0};
    wire        usable    = !fault_vec[chan_q];
    wire        rc_chan   = (chan_q == 3'd1) && sif.res_cancel;
    wire [31:0] load_cyc  = 32'(CONV_CYC - 1) + (rc_chan ? 32'(RC_EXTRA_CYC) : 32'h0);
    wire tlm_chan_t nxt_chan = (chan_q == 3'd4) ? 3'd0 : chan_q + 3'd1;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= TLM_SEQ_PICK;
            chan_q  <= 3'd0;
            cnt_q   <= 32'h0;
            start_q <= 1'b0;
            end_q   <= 1'b0;
        end
        else
        begin
            start_q <= 1'b0;
            end_q   <= 1'b0;
            case (state_q)
                TLM_SEQ_PICK:
                    if (usable && !sif.halt)
                    begin
                        start_q <= 1'b1;
                        cnt_q   <= load_cyc;
                        state_q <= TLM_SEQ_CONV;
                    end
                    else if (!usable)
                        chan_q <= nxt_chan;
                TLM_SEQ_CONV:
                    if (cnt_q == 32'h0)
                    begin
                        end_q   <= 1'b1;
                        state_q <= TLM_SEQ_DONE;
                    end
                    else
                        cnt_q <= cnt_q - 32'h1;
                TLM_SEQ_DONE:
                begin
                    chan_q  <= nxt_chan;
                    state_q <= TLM_SEQ_PICK;
                end
                default:
                    state_q <= TLM_SEQ_PICK;
            endcase
        end
    end

    assign sif.conv_start = start_q;
    assign sif.conv_end   = end_q;
    assign sif.conv_chan  = chan_q;

    chk_rc_extra_time: assert property (@(posedge clk) disable iff (!rst_n)
        (state_q == TLM_SEQ_PICK && usable && !sif.halt && rc_chan)
        |=> cnt_q == 32'(CONV_CYC - 1) + 32'(RC_EXTRA_CYC))
        else $error("cancellation did not lengthen channel 1 conversion");
    chk_skip_faulted: assert property (@(posedge clk) disable iff (!rst_n)
        sif.conv_start |-> !fault_vec[chan_q] || !$past(fault_vec[chan_q]))
        else $error("conversion started on a faulted channel");
endmodule
`default_nettype wire

// *** tlm_alarm_top.sv ***
// Limit alarm, masks and status of a five-channel temperature monitor.
// Register port is driven by an SMBus engine on smb_clk; results arrive on core_clk.
`timescale 1ns/100ps
`default_nettype none
`include "tlm_params.svh"
module tlm_alarm_top #(
    parameter int unsigned CONV_CYC     = `TLM_CONV_CYC,
    parameter int unsigned RC_EXTRA_CYC = `TLM_RC_EXTRA_CYC
) (
    input  wire logic                     core_clk,
    input  wire logic                     resetn,
    input  wire logic                     smb_clk,
    input  wire logic [7:0]               reg_addr,
    input  wire logic                     reg_wr_en,
    input  wire logic [7:0]               reg_wdata,
    input  wire logic                     reg_rd_en,
    input  wire logic                     ara_done,
    output var  logic [7:0]               reg_rdata,
    input  wire tlm_pkg::tlm_temp_t       adc_temp,
    input  wire tlm_pkg::tlm_temp_t [4:0] alert_limit,
    input  wire tlm_pkg::tlm_temp_t       trip_limit1,
    input  wire tlm_pkg::tlm_temp_t       trip_limit4,
    input  wire logic [3:0]               diode_fault_in,
    output logic                          conv_start,
    output tlm_pkg::tlm_chan_t            conv_chan,
    output var  logic                     alert_n,
    output var  logic                     thermal_trip_out_n
);
    import tlm_pkg::*;

    function automatic logic [6:0] chan_bit(input tlm_chan_t ch);
        logic [6:0] b;
        b = 7'h00;
        case (ch)
            3'd0:    b = 7'h40;
            3'd1:    b = 7'h01;
            3'd2:    b = 7'h02;
            3'd3:    b = 7'h04;
            3'd4:    b = 7'h08;
            default: b = 7'h00;
        endcase
        return b;
    endfunction

    // Reset release, one pair per domain
    logic [1:0] rst_core_q;
    logic [1:0] rst_link_q;
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            rst_core_q <= 2'b00;
        else
            rst_core_q <= {rst_core_q[0], 1'b1};
    end
    always_ff @(posedge smb_clk or negedge resetn)
    begin
        if (!resetn)
            rst_link_q <= 2'b00;
        else
            rst_link_q <= {rst_link_q[0], 1'b1};
    end
    wire rst_core_n = rst_core_q[1];
    wire rst_link_n = rst_link_q[1];

    // Link side: configuration and read strobes
    logic [7:0] cfg1_q;
    logic [7:0] cfg2_q;
    logic [7:0] cfg3_q;
    logic [7:0] rdata_q;
    logic [2:0] tgl_link_q;
    logic [6:0] flag1_ls1_q;
    logic [6:0] flag1_ls2_q;
    logic [3:0] flag2_ls1_q;
    logic [3:0] flag2_ls2_q;
    // Core-side flags, declared early: the link-side synchronisers read them
    logic [6:0] flag1_q;
    logic [3:0] flag2_q;

    wire wr_cfg1  = reg_wr_en && (reg_addr == `TLM_ADDR_CFG1);
    wire wr_cfg2  = reg_wr_en && (reg_addr == `TLM_ADDR_CFG2);
    wire wr_cfg3  = reg_wr_en && (reg_addr == `TLM_ADDR_CFG3);
    wire rd_stat1 = reg_rd_en && (reg_addr == `TLM_ADDR_STAT1);
    wire rd_stat2 = reg_rd_en && (reg_addr == `TLM_ADDR_STAT2);
    // Self-clearing soft reset; the bit never reads back as one
    wire soft_por = wr_cfg1 && reg_wdata[`TLM_CFG1_POR_BIT];

    wire [7:0] rd_mux =
        (reg_addr == `TLM_ADDR_CFG1)  ? cfg1_q :
        (reg_addr == `TLM_ADDR_CFG2)  ? cfg2_q :
        (reg_addr == `TLM_ADDR_CFG3)  ? cfg3_q :
        (reg_addr == `TLM_ADDR_STAT1) ? {1'b0, flag1_ls2_q} :
        (reg_addr == `TLM_ADDR_STAT2) ? {4'h0, flag2_ls2_q} : 8'h00;

    always_ff @(posedge smb_clk or negedge rst_link_n)
    begin
        if (!rst_link_n)
        begin
            cfg1_q <= `TLM_CFG_RESET;
            cfg2_q <= `TLM_CFG_RESET;
            cfg3_q <= `TLM_CFG_RESET;
        end
        else if (soft_por)
        begin
            cfg1_q <= `TLM_CFG_RESET;
            cfg2_q <= `TLM_CFG_RESET;
            cfg3_q <= `TLM_CFG_RESET;
        end
        else
        begin
            if (wr_cfg1)
                cfg1_q <= reg_wdata & `TLM_CFG1_WMASK;
            if (wr_cfg2)
                cfg2_q <= reg_wdata & `TLM_CFG2_WMASK;
            if (wr_cfg3)
                cfg3_q <= reg_wdata & `TLM_CFG3_WMASK;
        end
    end

    chk_soft_por_clear: assert property (@(posedge smb_clk) disable iff (!rst_link_n)
        soft_por |=> (cfg2_q == `TLM_CFG_RESET) && (cfg3_q == `TLM_CFG_RESET))
        else $error("soft reset left a mask bit set");
    chk_mask_reserved: assert property (@(posedge smb_clk) disable iff (!rst_link_n)
        ((cfg2_q & ~`TLM_CFG2_WMASK) == 8'h00) && ((cfg3_q & ~`TLM_CFG3_WMASK) == 8'h00))
        else $error("reserved mask bit holds a one");

    always_ff @(posedge smb_clk or negedge rst_link_n)
    begin
        if (!rst_link_n)
        begin
            rdata_q     <= 8'h00;
            tgl_link_q  <= 3'b000;
            flag1_ls1_q <= 7'h00;
            flag1_ls2_q <= 7'h00;
            flag2_ls1_q <= 4'h0;
            flag2_ls2_q <= 4'h0;
        end
        else
        begin
            if (reg_rd_en)
                rdata_q <= rd_mux;
            tgl_link_q  <= tgl_link_q ^ {ara_done, rd_stat2, rd_stat1};
            flag1_ls1_q <= flag1_q;
            flag1_ls2_q <= flag1_ls1_q;
            flag2_ls1_q <= flag2_q;
            flag2_ls2_q <= flag2_ls1_q;
        end
    end
    assign reg_rdata = rdata_q;

    // Core side: synchronised configuration, events and fault pins
    logic [6:0] mlim_s1_q;
    logic [6:0] mlim_s2_q;
    logic [3:0] mtrip_s1_q;
    logic [3:0] mtrip_s2_q;
    logic [1:0] ctl_s1_q;
    logic [1:0] ctl_s2_q;
    logic [3:0] fault_s1_q;
    logic [3:0] fault_s2_q;
    logic [2:0] tgl_s1_q;
    logic [2:0] tgl_s2_q;
    logic [2:0] tgl_s3_q;

    always_ff @(posedge core_clk or negedge rst_core_n)
    begin
        if (!rst_core_n)
        begin
            mlim_s1_q  <= 7'h00;
            mlim_s2_q  <= 7'h00;
            mtrip_s1_q <= 4'h0;
            mtrip_s2_q <= 4'h0;
            ctl_s1_q   <= 2'b00;
            ctl_s2_q   <= 2'b00;
            fault_s1_q <= 4'h0;
            fault_s2_q <= 4'h0;
            tgl_s1_q   <= 3'b000;
            tgl_s2_q   <= 3'b000;
            tgl_s3_q   <= 3'b000;
        end
        else
        begin
            mlim_s1_q  <= cfg2_q[6:0];
            mlim_s2_q  <= mlim_s1_q;
            mtrip_s1_q <= cfg3_q[3:0];
            mtrip_s2_q <= mtrip_s1_q;
            ctl_s1_q   <= {cfg1_q[`TLM_CFG1_STOP_BIT], cfg1_q[`TLM_CFG1_RC_BIT]};
            ctl_s2_q   <= ctl_s1_q;
            fault_s1_q <= diode_fault_in;
            fault_s2_q <= fault_s1_q;
            tgl_s1_q   <= tgl_link_q;
            tgl_s2_q   <= tgl_s1_q;
            tgl_s3_q   <= tgl_s2_q;
        end
    end
    wire [2:0] ev_pulse  = tgl_s2_q ^ tgl_s3_q;
    wire       rd1_pulse = ev_pulse[0];
    wire       rd2_pulse = ev_pulse[1];
    wire       ara_pulse = ev_pulse[2];
    wire [6:0] mask_lim  = mlim_s2_q;
    wire [3:0] mask_trip = mtrip_s2_q;

    tlm_seq_if sif ();
    assign sif.halt       = ctl_s2_q[1];
    assign sif.res_cancel = ctl_s2_q[0];
    assign sif.fault      = fault_s2_q;

    tlm_conv_seq #(
        .CONV_CYC     (CONV_CYC),
        .RC_EXTRA_CYC (RC_EXTRA_CYC)
    ) u_seq (
        .clk   (core_clk),
        .rst_n (rst_core_n),
        .sif   (sif.seq)
    );
    assign conv_start = sif.conv_start;
    assign conv_chan  = sif.conv_chan;

    // Compare at conversion end
    wire tlm_chan_t   ch        = sif.conv_chan;
    wire [6:0]        ch_bit    = chan_bit(ch);
    wire [3:0]        tr_bit    = ch_bit[3:0] & 4'h9;
    wire              trip_ch   = (ch == 3'd1) || (ch == 3'd4);
    wire signed [8:0] t9        = {adc_temp[7], adc_temp};
    wire signed [8:0] lim9      = (ch <= 3'd4) ? {alert_limit[ch][7], alert_limit[ch]} : 9'sd0;
    wire tlm_temp_t   trl       = (ch == 3'd4) ? trip_limit4 : trip_limit1;
    wire signed [8:0] trl9      = {trl[7], trl};
    wire              over_lim  = t9 > lim9;
    wire              over_trip = t9 > trl9;
    wire              below_hys = t9 < (trl9 - `TLM_TRIP_HYST_DEGC);
    wire [6:0] set1     = (sif.conv_end && over_lim) ? ch_bit : 7'h00;
    wire [3:0] trip_hit = (sif.conv_end && trip_ch && over_trip) ? tr_bit : 4'h0;
    wire [3:0] trip_rel = (sif.conv_end && trip_ch && below_hys) ? tr_bit : 4'h0;

    logic [3:0] trip_act_q;
    logic       alert_lat_q;
    logic       alert_n_q;
    logic       trip_n_q;

    // New events win over a clear in the same cycle
    wire [6:0] flag1_d    = set1 | (flag1_q & ~{7{rd1_pulse}});
    wire [3:0] flag2_d    = trip_hit | (flag2_q & ~{4{rd2_pulse}});
    wire [3:0] trip_act_d = trip_hit | (trip_act_q & ~trip_rel);
    wire       lat_set    = |(set1 & ~mask_lim);
    wire       lat_d      = lat_set | (alert_lat_q & ~(rd1_pulse | ara_pulse));
    wire       alert_on   = lat_d & |(flag1_d & ~mask_lim);
    wire       trip_on    = |(trip_act_d & ~mask_trip);

    always_ff @(posedge core_clk or negedge rst_core_n)
    begin
        if (!rst_core_n)
        begin
            flag1_q     <= 7'h00;
            flag2_q     <= 4'h0;
            trip_act_q  <= 4'h0;
            alert_lat_q <= 1'b0;
            alert_n_q   <= 1'b1;
            trip_n_q    <= 1'b1;
        end
        else
        begin
            flag1_q     <= flag1_d;
            flag2_q     <= flag2_d;
            trip_act_q  <= trip_act_d;
            alert_lat_q <= lat_d;
            alert_n_q   <= ~alert_on;
            trip_n_q    <= ~trip_on;
        end
    end
    assign alert_n            = alert_n_q;
    assign thermal_trip_out_n = trip_n_q;

    chk_local_alert_mask: assert property (@(posedge core_clk) disable iff (!rst_core_n)
        (sif.conv_end && ch == 3'd0 && mask_lim[6] && !alert_lat_q) |=> alert_n)
        else $error("masked local channel drove the limit interrupt");
    chk_remote_alert_mask: assert property (@(posedge core_clk) disable iff (!rst_core_n)
        (sif.conv_end && ch != 3'd0 && |(mask_lim & ch_bit) && !alert_lat_q) |=> alert_n)
        else $error("masked remote channel drove the limit interrupt");
    chk_trip_out_mask: assert property (@(posedge core_clk) disable iff (!rst_core_n)
        !thermal_trip_out_n |-> |(trip_act_q & ~$past(mask_trip)))
        else $error("trip output low with no unmasked trip");
    chk_alert_clear_now: assert property (@(posedge core_clk) disable iff (!rst_core_n)
        ((rd1_pulse || ara_pulse) && !sif.conv_end) |=> alert_n)
        else $error("limit interrupt not released by read or alert response");
    chk_alert_reassert: assert property (@(posedge core_clk) disable iff (!rst_core_n)
        (sif.conv_end && |(set1 & ~mask_lim)) |=> !alert_n)
        else $error("limit interrupt not reasserted at conversion end");
    chk_trip_flag_clear: assert property (@(posedge core_clk) disable iff (!rst_core_n)
        (rd2_pulse && trip_hit == 4'h0) |=> flag2_q == 4'h0)
        else $error("trip status not cleared by status 2 read");
    chk_trip_read_keeps: assert property (@(posedge core_clk) disable iff (!rst_core_n)
        (rd2_pulse && !sif.conv_end && $stable(mask_trip)) |=> $stable(thermal_trip_out_n))
        else $error("status 2 read changed the trip output");
    chk_trip_hysteresis: assert property (@(posedge core_clk) disable iff (!rst_core_n)
        (|(trip_act_q & tr_bit) && !(sif.conv_end && below_hys)) |=> |(trip_act_q & $past(tr_bit)))
        else $error("trip released above threshold minus hysteresis");
    chk_trip_assert: assert property (@(posedge core_clk) disable iff (!rst_core_n)
        (sif.conv_end && trip_ch && over_trip && !(|(mask_trip & tr_bit)) && $stable(mask_trip))
        |=> !thermal_trip_out_n)
        else $error("trip output not asserted above threshold");
    chk_limit_flag_set: assert property (@(posedge core_clk) disable iff (!rst_core_n)
        (sif.conv_end && over_lim) |=> (flag1_q & $past(ch_bit)) != 7'h00)
        else $error("limit status bit not set on over-limit result");
    chk_alert_follows: assert property (@(posedge core_clk) disable iff (!rst_core_n)
        !alert_n |-> |(flag1_q & ~$past(mask_lim)))
        else $error("limit interrupt low without an unmasked flag");
endmodule
`default_nettype wire

// *** tlm_temp_model.sv ***
// Temperature source model: one result per conversion for the alarm block.
// Assumes conv_start and conv_chan are registered on the core clock.
`timescale 1ns/100ps
`default_nettype none
module tlm_temp_model
    import tlm_pkg::*;
(
    input  wire logic                     clk,
    input  wire logic                     conv_start,
    input  wire tlm_pkg::tlm_chan_t       conv_chan,
    input  wire tlm_pkg::tlm_temp_t [4:0] temps,
    output var  tlm_pkg::tlm_temp_t       adc_temp
);
    // Latched at start so a bench change mid-conversion cannot tear a result
    always_ff @(posedge clk)
    begin
        if (conv_start)
        begin
            adc_temp <= temps[conv_chan];
        end
    end
endmodule
`default_nettype wire

// *** temp_limit_alarm_mask_status_tb_top.sv ***
// Bench of the limit alarm block: register port on smb_clk, results from a temperature model.
// Assumes shortened conversions through the top's parameters.
`timescale 1ns/100ps
`default_nettype none
module temp_limit_alarm_mask_status_tb_top;
    import tlm_pkg::*;
    localparam int CONV = 8;
    localparam int RCX  = 20;
    logic            core_clk       = 1'b0;
    logic            smb_clk        = 1'b0;
    logic            resetn         = 1'b0;
    logic [7:0]      reg_addr       = 8'h00;
    logic            reg_wr_en      = 1'b0;
    logic [7:0]      reg_wdata      = 8'h00;
    logic            reg_rd_en      = 1'b0;
    logic            ara_done       = 1'b0;
    logic [7:0]      reg_rdata;
    tlm_temp_t       adc_temp;
    tlm_temp_t [4:0] alert_limit    = '0;
    tlm_temp_t [4:0] temps          = '0;
    tlm_temp_t       trip_limit1    = '0;
    tlm_temp_t       trip_limit4    = '0;
    logic [3:0]      diode_fault_in = 4'h0;
    logic            conv_start;
    tlm_chan_t       conv_chan;
    logic            alert_n;
    logic            thermal_trip_out_n;
    logic [7:0]      rd;
    tlm_temp_t       thr;
    int              n_errors = 0;
    int              n_checks = 0;
    int              seed     = 32'hb6442cd3;
    int              n_ch3    = 0;
    int              d0;
    int              d1;
    int              k;

    always #12.5 core_clk = ~core_clk;
    always #16 smb_clk = ~smb_clk;

    tlm_alarm_top #(.CONV_CYC(CONV), .RC_EXTRA_CYC(RCX)) tlm_alarm_top_inst (
        .core_clk(core_clk), .resetn(resetn), .smb_clk(smb_clk), .reg_addr(reg_addr),
        .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .ara_done(ara_done),
        .reg_rdata(reg_rdata), .adc_temp(adc_temp), .alert_limit(alert_limit),
        .trip_limit1(trip_limit1), .trip_limit4(trip_limit4), .diode_fault_in(diode_fault_in),
        .conv_start(conv_start), .conv_chan(conv_chan), .alert_n(alert_n),
        .thermal_trip_out_n(thermal_trip_out_n));

    tlm_temp_model tlm_temp_model_inst (
        .clk(core_clk), .conv_start(conv_start), .conv_chan(conv_chan),
        .temps(temps), .adc_temp(adc_temp));

    function automatic logic at(input int ch);
        return conv_start === 1'b1 && conv_chan === ch[2:0];
    endfunction

    // Status and mask bit of a channel: local sits at bit 6, remote n at n-1
    function automatic logic [7:0] sbit(input int ch);
        return 8'h01 << ((ch == 0) ? 6 : ch - 1);
    endfunction

    always @(negedge core_clk)
        if (at(3))
            n_ch3++;

    task automatic complete_run();
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic [7:0] a, input logic [7:0] d, input logic wr);
        @(posedge smb_clk);
        #2;
        reg_addr = a;
        reg_wdata = d;
        reg_wr_en = wr;
        reg_rd_en = !wr;
        @(posedge smb_clk);
        #2;
        rd = reg_rdata;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        bus(a, 8'h00, 1'b0);
        chk(rd, exp);
    endtask

    // Two starts of the local channel: every unfaulted channel has converted since
    task automatic round();
        int n = 0;
        int c = 0;
        while (n < 2)
        begin
            @(negedge core_clk);
            if (at(0))
                n++;
            if (++c > 3000)
            begin
                n_errors++;
                complete_run();
            end
        end
        repeat (4) @(posedge core_clk);
        #2;
    endtask

    task automatic go();
        bus(8'h41, 8'h00, 1'b1);
        round();
    endtask

    // Stop bit, then long enough for the slowest conversion to finish
    task automatic halt();
        bus(8'h41, 8'h80, 1'b1);
        repeat (100) @(posedge core_clk);
    endtask

    task automatic lows();
        for (int i = 0; i < 5; i++)
            temps[i] = tlm_temp_t'(alert_limit[i] - 1 - ($random(seed) & 15));
    endtask

    task automatic dur(output int d);
        int c = 0;
        d = 0;
        while (!at(1) && c < 3000)
        begin
            @(negedge core_clk);
            c++;
        end
        do
        begin
            @(negedge core_clk);
            d++;
        end while (!at(2) && d < 3000);
        if (c >= 3000 || d >= 3000)
        begin
            n_errors++;
            complete_run();
        end
    endtask

    initial
    begin
        for (int i = 0; i < 5; i++)
            alert_limit[i] = tlm_temp_t'(20 + ($random(seed) & 31));
        trip_limit1 = tlm_temp_t'(60 + ($random(seed) & 31));
        trip_limit4 = tlm_temp_t'(60 + ($random(seed) & 31));
        lows();
        repeat (12) @(posedge core_clk);
        #2;
        resetn = 1'b1;
        repeat (4) @(posedge smb_clk);
        for (int a = 'h41; a < 'h46; a++)
            rdchk(a[7:0], 8'h00);
        chk(alert_n, 1'b1);
        chk(thermal_trip_out_n, 1'b1);
        bus(8'h42, 8'hff, 1'b1);
        rdchk(8'h42, 8'h4f);
        bus(8'h43, 8'hff, 1'b1);
        rdchk(8'h43, 8'h09);
        bus(8'h50, 8'hff, 1'b1);
        rdchk(8'h50, 8'h00);
        bus(8'h41, 8'hbf, 1'b1);
        rdchk(8'h41, 8'hb8);
        bus(8'h41, 8'h40, 1'b1);
        rdchk(8'h41, 8'h00);
        rdchk(8'h42, 8'h00);
        rdchk(8'h43, 8'h00);
        for (int ch = 0; ch < 5; ch++)
        begin
            lows();
            temps[ch] = tlm_temp_t'(alert_limit[ch] + 1 + ($random(seed) & 7));
            go();
            chk(alert_n, 1'b0);
            halt();
            rdchk(8'h44, sbit(ch));
            repeat (10) @(negedge core_clk);
            chk(alert_n, 1'b1);
            rdchk(8'h44, 8'h00);
            chk(alert_n, 1'b1);
            go();
            chk(alert_n, 1'b0);
            halt();
            bus(8'h00, 8'h00, 1'b0);
            @(posedge smb_clk);
            #2;
            ara_done = 1'b1;
            @(posedge smb_clk);
            #2;
            ara_done = 1'b0;
            repeat (10) @(negedge core_clk);
            chk(alert_n, 1'b1);
            rdchk(8'h44, sbit(ch));
            bus(8'h42, sbit(ch), 1'b1);
            go();
            chk(alert_n, 1'b1);
            halt();
            rdchk(8'h44, sbit(ch));
            bus(8'h42, 8'h00, 1'b1);
        end
        for (int j = 0; j < 2; j++)
        begin
            k = j ? 4 : 1;
            thr = j ? trip_limit4 : trip_limit1;
            lows();
            temps[k] = thr;
            go();
            chk(thermal_trip_out_n, 1'b1);
            temps[k] = thr + 1;
            round();
            chk(thermal_trip_out_n, 1'b0);
            halt();
            bus(8'h45, 8'h00, 1'b0);
            chk(rd[k-1], 1'b1);
            repeat (10) @(negedge core_clk);
            chk(thermal_trip_out_n, 1'b0);
            rdchk(8'h45, 8'h00);
            temps[k] = thr - 4;
            go();
            chk(thermal_trip_out_n, 1'b0);
            temps[k] = thr - 5;
            round();
            chk(thermal_trip_out_n, 1'b1);
            bus(8'h43, sbit(k), 1'b1);
            temps[k] = thr + 1;
            round();
            chk(thermal_trip_out_n, 1'b1);
            bus(8'h43, 8'h00, 1'b1);
            temps[k] = thr - 5;
            round();
        end
        lows();
        diode_fault_in = 4'b0100;
        bus(8'h42, 8'h04, 1'b1);
        round();
        n_ch3 = 0;
        round();
        chk(n_ch3, 0);
        diode_fault_in = 4'b0000;
        round();
        n_ch3 = 0;
        round();
        chk(n_ch3 != 0, 1'b1);
        dur(d0);
        bus(8'h41, 8'h08, 1'b1);
        round();
        dur(d1);
        chk(d1 - d0, RCX);
        complete_run();
    end
endmodule
`default_nettype wire
